//--- rtl/clock_mode_cfg.svh
`ifndef CLOCK_MODE_CFG_SVH
`define CLOCK_MODE_CFG_SVH

// Mode pin encodings
`define MODE_MUL4        3'h7
`define MODE_MUL3        3'h6
`define MODE_MUL2        3'h5
`define MODE_MUL5        3'h4
`define MODE_DIRECT      3'h3
`define MODE_MUL1P5      3'h2
`define MODE_PRESCALE    3'h1
`define MODE_MUL2P5      3'h0
`define MODE_RESET_VAL   3'h7

// Watchdog overflow in PLL clock cycles
`define WDOG_LIMIT       5'h10
// Watchdog disable bit position in system config register
`define WDOG_DIS_BIT_POS 4

`endif

//--- rtl/clock_mode_pkg.sv
package clock_mode_pkg;
  typedef enum logic [2:0] {
    SRC_PLL_MUL  = 3'b000,
    SRC_DIRECT   = 3'b001,
    SRC_PRESCALE = 3'b010,
    SRC_FAILSAFE = 3'b011
  } clk_src_t;
endpackage : clock_mode_pkg

//--- rtl/cpu_clock_mode_select.sv
`timescale 1ns/10ps
`include "clock_mode_cfg.svh"
// Notes on behaviour
// - CPU clock source chosen from three mode pins sampled on the first clock after reset release.
// - Codes: 111 x4, 110 x3, 101 x2, 100 x5, 011 direct, 010 x1.5, 001 /2, 000 x2.5.
// - Code 001 divides oscillator input by two.
// - Prescaler phases each last one input period.
// - Codes 011 and 001 only: watchdog enabled, PLL free-runs and clocks watchdog; disabled, PLL off unless failed over.
// - Code 011 drives CPU clock from oscillator input; PLL off only while watchdog disabled.
// - Direct mode phases follow input duty; two phases make one period.
// - Both CPU clock edges mark half-period timing units.
// - Watchdog enabled after reset; system config bit 4 disables it.
// - Watchdog counts PLL clocks, cleared per input edge, fails at 16.
// - On failure switch to PLL clock, flag interrupt, stay until reset.

module cpu_clock_mode_select (
  input  wire logic       clock,
  input  wire logic       rst_n,
  input  wire logic       oscillator_input_pin,
  input  wire logic [2:0] clock_mode_pins,
  input  wire logic       pll_clock_in,
  input  wire logic       config_write,
  input  wire logic [7:0] system_config_register,
  input  wire logic       pll_mult_clock_in,
  output logic            cpu_clock,
  output logic            clock_half_period,
  output logic            pll_enable,
  output logic            osc_fail_interrupt_request,
  output logic [2:0]      mode_latched
);
  logic [2:0]                 mode_reg;
  logic                       captured_reg;
  logic                       wdog_disable_reg;
  logic                       osc_d_reg;
  logic                       pll_d_reg;
  logic                       presc_reg;
  logic                       cpu_clock_reg;
  logic                       half_reg;
  logic                       pll_en_reg;
  logic                       irq_reg;
  logic                       switched_reg;
  clock_mode_pkg::clk_src_t   src;
  wire                        osc_edge;
  wire                        osc_rise;
  wire                        pll_tick;
  wire                        wdog_fail;
  wire                        mode_direct;
  wire                        mode_prescale;
  wire                        wdog_active;
  logic                       clk_next;

  // Mode decode
  assign mode_direct   = (mode_reg == `MODE_DIRECT);
  assign mode_prescale = (mode_reg == `MODE_PRESCALE);
  assign osc_edge      = oscillator_input_pin ^ osc_d_reg;
  assign osc_rise      = oscillator_input_pin & ~osc_d_reg;
  assign pll_tick      = pll_clock_in & ~pll_d_reg;
  assign wdog_active   = (mode_direct | mode_prescale) & ~wdog_disable_reg;

  // Mode capture: first clock after reset release, then frozen
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      mode_reg     <= `MODE_RESET_VAL;
      captured_reg <= 1'b0;
    end else if (!captured_reg) begin
      mode_reg     <= clock_mode_pins;
      captured_reg <= 1'b1;
    end
  end

  // Watchdog disable bit, cleared by every reset
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      wdog_disable_reg <= 1'b0;
    else if (config_write)
      wdog_disable_reg <= system_config_register[`WDOG_DIS_BIT_POS];
  end

  // Edge history of the input clocks
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      osc_d_reg <= 1'b0;
      pll_d_reg <= 1'b0;
    end else begin
      osc_d_reg <= oscillator_input_pin;
      pll_d_reg <= pll_clock_in;
    end
  end

  // Oscillator watchdog, armed only after mode capture
  osc_watchdog u_wdog (
    .clock    (clock),
    .rst_n    (rst_n),
    .enable   (wdog_active & captured_reg),
    .pll_tick (pll_tick),
    .osc_edge (osc_edge),
    .fail     (wdog_fail)
  );

  // Source selection, failsafe overrides the latched mode
  always_comb begin
    if (switched_reg)
      src = clock_mode_pkg::SRC_FAILSAFE;
    else if (mode_direct)
      src = clock_mode_pkg::SRC_DIRECT;
    else if (mode_prescale)
      src = clock_mode_pkg::SRC_PRESCALE;
    else
      src = clock_mode_pkg::SRC_PLL_MUL;
  end

  // Next CPU clock level per source
  always_comb begin
    case (src)
      clock_mode_pkg::SRC_DIRECT:   clk_next = oscillator_input_pin;
      clock_mode_pkg::SRC_PRESCALE: clk_next = presc_reg;
      clock_mode_pkg::SRC_FAILSAFE: clk_next = pll_clock_in;
      clock_mode_pkg::SRC_PLL_MUL:  clk_next = pll_mult_clock_in;
      default:                      clk_next = 1'b0;
    endcase
  end

  // Prescaler toggles on each input rise: each phase one input period
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      presc_reg <= 1'b0;
    else if (osc_rise)
      presc_reg <= ~presc_reg;
  end

  // Failure latch; only reset returns to the external clock
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      switched_reg <= 1'b0;
      irq_reg      <= 1'b0;
    end else begin
      irq_reg <= 1'b0;
      if (wdog_fail && wdog_active && !switched_reg) begin
        switched_reg <= 1'b1;
        irq_reg      <= 1'b1;
      end
    end
  end

  // PLL power: on for multiply modes, or free-running for watchdog
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n)
      pll_en_reg <= 1'b1;
    else
      pll_en_reg <= (!mode_direct && !mode_prescale) || wdog_active || switched_reg;
  end

  // CPU clock and half-period pulse on either edge
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      cpu_clock_reg <= 1'b0;
      half_reg      <= 1'b0;
    end else begin
      cpu_clock_reg <= clk_next;
      half_reg      <= clk_next ^ cpu_clock_reg;
    end
  end

  assign cpu_clock                  = cpu_clock_reg;
  assign clock_half_period          = half_reg;
  assign pll_enable                 = pll_en_reg;
  assign osc_fail_interrupt_request = irq_reg;
  assign mode_latched               = mode_reg;
endmodule : cpu_clock_mode_select

//--- rtl/osc_watchdog.sv
`timescale 1ns/10ps
`include "clock_mode_cfg.svh"

module osc_watchdog (
  input  wire logic clock,
  input  wire logic rst_n,
  input  wire logic enable,
  input  wire logic pll_tick,
  input  wire logic osc_edge,
  output logic      fail
);
  logic [4:0] count_reg;
  logic       fail_reg;

  // Count PLL ticks, cleared by each oscillator transition
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      count_reg <= 5'h00;
      fail_reg  <= 1'b0;
    end else if (!enable || osc_edge) begin
      count_reg <= 5'h00;
    end else if (pll_tick && !fail_reg) begin
      if (count_reg == `WDOG_LIMIT - 5'h01)
        fail_reg <= 1'b1;
      count_reg <= count_reg + 5'h01;
    end
  end

  assign fail = fail_reg;
endmodule : osc_watchdog

//--- tb/cpu_clock_mode_select_assertions.sv
`timescale 1ns/10ps
module cpu_clock_mode_select_assertions (
  input wire logic       clock,
  input wire logic       rst_n,
  input wire logic       oscillator_input_pin,
  input wire logic [2:0] clock_mode_pins,
  input wire logic       pll_clock_in,
  input wire logic       config_write,
  input wire logic [7:0] system_config_register,
  input wire logic       cpu_clock,
  input wire logic       clock_half_period,
  input wire logic       pll_enable,
  input wire logic       osc_fail_interrupt_request,
  input wire logic [2:0] mode_latched
);
  logic [5:0] still_reg;
  logic       failed_reg;
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  // Quiet oscillator cycles, failover memory
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      still_reg  <= 6'h00;
      failed_reg <= 1'b0;
    end else begin
      still_reg  <= $changed(oscillator_input_pin) ? 6'h00 : still_reg + {5'h00, ~&still_reg};
      failed_reg <= failed_reg | osc_fail_interrupt_request;
    end
  end
  // First edge that sees reset released
  sequence s_capture;
    $rose(rst_n);
  endsequence
  sequence s_settled;
    $past(rst_n, 2) && $past(rst_n);
  endsequence
  AST_HALF_SET: assert property ($changed(cpu_clock) |-> clock_half_period)
    else $error("half period pulse missing");
  AST_HALF_ONLY: assert property (clock_half_period |-> $changed(cpu_clock))
    else $error("half period pulse without edge");
  AST_MODE_CAP: assert property (s_capture |=> mode_latched == $past(clock_mode_pins))
    else $error("mode not captured");
  AST_MODE_HOLD: assert property (s_settled |-> $stable(mode_latched))
    else $error("mode changed after capture");
  AST_IRQ_ONCE: assert property (osc_fail_interrupt_request |=> !osc_fail_interrupt_request [*8])
    else $error("fail request repeated");
  AST_IRQ_CAUSE: assert property (osc_fail_interrupt_request |-> still_reg >= 6'h10 &&
    (mode_latched == 3'h3 || mode_latched == 3'h1)) else $error("fail request without cause");
  AST_PLL_OFF: assert property (config_write && system_config_register[4] |-> ##[1:2] !pll_enable)
    else $error("pll not powered off");
  AST_DIRECT: assert property (mode_latched == 3'h3 && $stable(mode_latched) && !failed_reg
    |-> cpu_clock == $past(oscillator_input_pin)) else $error("direct clock wrong");
  AST_FAILSAFE: assert property (failed_reg && $past(failed_reg)
    |-> cpu_clock == $past(pll_clock_in)) else $error("failsafe clock wrong");
endmodule : cpu_clock_mode_select_assertions
bind cpu_clock_mode_select cpu_clock_mode_select_assertions chk (
  .clock(clock), .rst_n(rst_n), .oscillator_input_pin(oscillator_input_pin),
  .clock_mode_pins(clock_mode_pins), .pll_clock_in(pll_clock_in), .config_write(config_write),
  .system_config_register(system_config_register), .cpu_clock(cpu_clock),
  .clock_half_period(clock_half_period), .pll_enable(pll_enable),
  .osc_fail_interrupt_request(osc_fail_interrupt_request), .mode_latched(mode_latched));

//--- tb/cpu_clock_mode_select_tb.sv
`timescale 1ns/10ps
module cpu_clock_mode_select_tb;
  logic       clock = 1'b0, rst_n = 1'b0, run = 1'b1, wr = 1'b0;
  logic [2:0] pins = 3'h7;
  logic [7:0] cfg = 8'h00;
  logic       osc, pll, pmul, cpu, half, pll_en, irq;
  logic [2:0] mode;
  int         n_errors = 0;
  int         n_tests = 0;
  // Clock and far side
  always #10 clock = ~clock;
  osc_source_model src (.clock(clock), .run(run), .pll_en(pll_en), .osc(osc), .pll(pll),
    .pll_mult(pmul));
  cpu_clock_mode_select dut (.clock(clock), .rst_n(rst_n), .oscillator_input_pin(osc),
    .clock_mode_pins(pins), .pll_clock_in(pll), .config_write(wr), .system_config_register(cfg),
    .pll_mult_clock_in(pmul), .cpu_clock(cpu), .clock_half_period(half), .pll_enable(pll_en),
    .osc_fail_interrupt_request(irq), .mode_latched(mode));
  task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_errors++;
      $display("mismatch %s expected %0h seen %0h", what, exp, seen);
    end
  endtask : check
  task automatic restart(input logic [2:0] code);
    pins <= code;
    run <= 1'b1;
    rst_n <= 1'b0;
    repeat (2) @(posedge clock);
    rst_n <= 1'b1;
    repeat (3) @(posedge clock);
  endtask : restart
  task automatic test_modes();
    int n_cpu, n_exp, n_half;
    logic c0, o0, m0;
    for (int k = 0; k < 8; k++) begin
      restart(k[2:0]);
      check("mode", mode, k[2:0]);
      check("pll on", pll_en, 1'b1);
      pins <= ~k[2:0];
      #1;
      {n_cpu, n_exp, c0, o0, m0} = {32'h0, 32'h0, cpu, osc, pmul};
      n_half = 0;
      repeat (60) begin
        @(posedge clock);
        #1;
        n_cpu += (cpu !== c0);
        n_exp += (k == 3) ? (osc !== o0) : (k == 1) ? (osc && !o0) : (pmul !== m0);
        n_half += half;
        {c0, o0, m0} = {cpu, osc, pmul};
      end
      @(posedge clock);
      check("cpu edges", (n_cpu - n_exp) inside {[-1:1]}, 1'b1);
      check("half pulses", n_half, n_cpu);
      check("mode held", mode, k[2:0]);
    end
    $display("test modes done");
  endtask : test_modes
  task automatic test_failover(input logic [2:0] code, input logic [7:0] exp);
    int n_irq = 0;
    restart(code);
    run <= 1'b0;
    repeat (200) begin
      @(posedge clock);
      #1;
      n_irq += irq;
    end
    run <= 1'b1;
    repeat (40) @(posedge clock);
    check("fail requests", n_irq, exp);
    $display("test failover done");
  endtask : test_failover
  task automatic test_disable();
    int n_irq = 0;
    restart(3'h3);
    wr <= 1'b1;
    cfg <= 8'hEF;
    @(posedge clock);
    wr <= 1'b0;
    repeat (3) @(posedge clock);
    check("pll kept", pll_en, 1'b1);
    wr <= 1'b1;
    cfg <= 8'h10;
    @(posedge clock);
    wr <= 1'b0;
    repeat (3) @(posedge clock);
    check("pll off", pll_en, 1'b0);
    run <= 1'b0;
    repeat (100) begin
      @(posedge clock);
      #1;
      n_irq += irq;
    end
    check("fail when disabled", n_irq, 8'h00);
    @(posedge clock);
    test_failover(3'h3, 8'h01);
    $display("test disable done");
  endtask : test_disable
  task automatic summarize();
    $display("tests %0d errors %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : summarize
  // Hang guard
  initial begin
    #100000;
    n_errors++;
    summarize();
  end
  initial begin
    test_modes();
    test_failover(3'h3, 8'h01);
    test_failover(3'h1, 8'h01);
    test_failover(3'h7, 8'h00);
    test_disable();
    summarize();
  end
endmodule : cpu_clock_mode_select_tb

//--- tb/osc_source_model.sv
`timescale 1ns/10ps
module osc_source_model (
  input  wire logic clock,
  input  wire logic run,
  input  wire logic pll_en,
  output logic      osc = 1'b0,
  output logic      pll = 1'b0,
  output logic      pll_mult = 1'b0
);
  logic [1:0] div_reg = 2'h0;
  // Crystal halts at its level when stopped; pll runs only when powered, pll_mult always toggles
  always @(posedge clock) begin
    div_reg <= (div_reg == 2'h2) ? 2'h0 : div_reg + 2'h1;
    if (run && div_reg == 2'h2) osc <= ~osc;
    if (pll_en) pll <= ~pll;
    pll_mult <= ~pll_mult;
  end
endmodule : osc_source_model
